// *** shared/quadrature_decoder_pkg.sv ***
// Register map, field positions and reset values of the shortcut and interrupt bank
package quadrature_decoder_pkg;
   // Register offsets (byte addresses)
   localparam logic [11:0] OFS_TASK_STOP  = 12'h004;
   localparam logic [11:0] OFS_TASK_BOTH  = 12'h008;
   localparam logic [11:0] OFS_TASK_STEPS = 12'h00C;
   localparam logic [11:0] OFS_TASK_DBLS  = 12'h010;
   localparam logic [11:0] OFS_EV_SAMPLE  = 12'h100;
   localparam logic [11:0] OFS_EV_REPORT  = 12'h104;
   localparam logic [11:0] OFS_EV_OVF     = 12'h108;
   localparam logic [11:0] OFS_EV_DOUBLE  = 12'h10C;
   localparam logic [11:0] OFS_EV_HALT    = 12'h110;
   localparam logic [11:0] OFS_LINKS      = 12'h200;
   localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
   localparam logic [11:0] OFS_STEP_TOT   = 12'h514;
   localparam logic [11:0] OFS_STEP_SNAP  = 12'h518;
   localparam logic [11:0] OFS_DBL_TOT    = 12'h544;
   localparam logic [11:0] OFS_DBL_SNAP   = 12'h548;
   localparam logic [11:0] OFS_REPORT_CNT = 12'h600;
   // Link bit positions in event_task_links
   localparam int LNK_REPORT_BOTH  = 0;
   localparam int LNK_SAMPLE_STOP  = 1;
   localparam int LNK_REPORT_STEPS = 2;
   localparam int LNK_REPORT_STOP  = 3;
   localparam int LNK_DOUBLE_DBLS  = 4;
   localparam int LNK_DOUBLE_STOP  = 5;
   localparam int LNK_SAMPLE_BOTH  = 6;
   localparam int LINKS_W          = 7;
   // Event bit positions, shared by flags and irq_enable_set
   localparam int EV_SAMPLE = 0;
   localparam int EV_REPORT = 1;
   localparam int EV_OVF    = 2;
   localparam int EV_DOUBLE = 3;
   localparam int EV_HALT   = 4;
   localparam int EV_N      = 5;
   // Widths and reset values
   localparam int                  REPORT_CNT_W   = 8;
   localparam logic [LINKS_W-1:0]  LINKS_RST      = 7'h00;
   localparam logic [EV_N-1:0]     IRQ_EN_RST     = 5'h00;
   localparam logic [EV_N-1:0]     EV_FLAGS_RST   = 5'h00;
   localparam logic [7:0]          REPORT_CNT_RST = 8'h0A;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/axil_regs_port.sv ***
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module axil_regs_port #(
   parameter int AW = 12
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Write channels
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   // Read channels
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   // Register side
   output logic               wr_en,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_strb,
   input  wire logic          wr_ok,
   output logic               rd_en,
   output logic [AW-1:0]      rd_addr,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_ok
);
   logic aw_held_r;
   logic w_held_r;

   // Each channel is held until both have arrived; no new one while a response waits
   assign awready = !aw_held_r && !bvalid;
   assign wready  = !w_held_r && !bvalid;
   assign wr_en   = aw_held_r && w_held_r && !bvalid;
   assign arready = !rvalid;
   assign rd_en   = arvalid && arready;
   assign rd_addr = araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         wr_addr   <= '0;
      end else if (awvalid && awready) begin
         aw_held_r <= 1'b1;
         wr_addr   <= awaddr;
      end else if (wr_en) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wr_data  <= '0;
         wr_strb  <= '0;
      end else if (wvalid && wready) begin
         w_held_r <= 1'b1;
         wr_data  <= wdata;
         wr_strb  <= wstrb;
      end else if (wr_en) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= quadrature_decoder_pkg::RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? quadrature_decoder_pkg::RESP_OKAY : quadrature_decoder_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= quadrature_decoder_pkg::RESP_OKAY;
      end else if (rd_en) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_ok ? quadrature_decoder_pkg::RESP_OKAY : quadrature_decoder_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

// *** hdl/event_total.sv ***
// Saturating transition total with an atomic snapshot-and-clear
`timescale 1ns/1ps
module event_total #(
   parameter int W        = 32,
   parameter bit IS_SIGNED = 1'b1
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Increment and task
   input  wire logic        inc_valid,
   input  wire logic [1:0]  inc,
   input  wire logic        snap,
   // Results
   output logic [W-1:0]     total,
   output logic [W-1:0]     snapshot,
   output logic             overflow
);
   logic [W:0] ext_total;
   logic [W:0] ext_inc;
   logic [W:0] sum;
   logic       ovf_c;

   assign ext_total = IS_SIGNED ? {total[W-1], total} : {1'b0, total};
   assign ext_inc   = {{(W-1){inc[1]}}, inc};
   assign sum       = ext_total + ext_inc;
   assign ovf_c     = IS_SIGNED ? (sum[W] != sum[W-1]) : sum[W];

   // Snapshot and clear in one edge; a step arriving then starts the new total
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         total    <= '0;
         snapshot <= '0;
      end else if (snap) begin
         snapshot <= total;
         total    <= inc_valid ? ext_inc[W-1:0] : '0;
      end else if (inc_valid && !ovf_c) begin
         total <= sum[W-1:0];
      end
   end

   // Total holds its limit rather than wrapping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow <= 1'b0;
      end else begin
         overflow <= inc_valid && !snap && ovf_c;
      end
   end
endmodule

// *** hdl/quad_decoder_shortcut_irq.sv ***
// Event flags, event-to-task links and interrupt enables of the quadrature decoder
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module quad_decoder_shortcut_irq #(
   parameter int AW    = 12,
   parameter int STEP_W = 32,
   parameter int DBL_W  = 4
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // AXI4-Lite write channels
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   // AXI4-Lite read channels
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   // Sampling core
   input  wire logic          sample_strobe,
   input  wire logic [1:0]    sample_value,
   input  wire logic          double_strobe,
   input  wire logic          halt_done,
   output logic               stop_task,
   // Interrupt
   output logic               irq
);
   typedef enum {
      CNT_IDLE,
      CNT_RUN
   } cnt_state_e;

   // Register strobes
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [31:0]   wr_data;
   logic [3:0]    wr_strb;
   logic          wr_ok;
   logic          rd_en;
   logic [AW-1:0] rd_addr;
   logic [31:0]   rd_data;
   logic          rd_ok;
   logic          wr_lane0;

   // Stored state
   logic [quadrature_decoder_pkg::LINKS_W-1:0]      links_r;
   logic [quadrature_decoder_pkg::EV_N-1:0]         irq_en_r;
   logic [quadrature_decoder_pkg::EV_N-1:0]         ev_flag_r;
   logic [quadrature_decoder_pkg::REPORT_CNT_W-1:0] report_cnt_r;
   logic [quadrature_decoder_pkg::REPORT_CNT_W-1:0] sample_cnt_r;
   logic [quadrature_decoder_pkg::REPORT_CNT_W-1:0] report_lim;
   logic                              report_due_r;
   cnt_state_e                        cnt_state_r;

   // Events and tasks
   logic [quadrature_decoder_pkg::EV_N-1:0] ev_pulse;
   logic                      new_sample_event;
   logic                      motion_report_event;
   logic                      double_step_report_event;
   logic                      total_overflow_event;
   logic                      snap_clear_both_task;
   logic                      snap_clear_steps_task;
   logic                      snap_clear_doubles_task;
   logic                      stop_nxt;

   // Totals
   logic [STEP_W-1:0] step_total;
   logic [STEP_W-1:0] step_total_snapshot;
   logic              step_ovf;
   logic [DBL_W-1:0]  double_step_total;
   logic [DBL_W-1:0]  double_step_snapshot;
   logic              dbl_ovf;

   function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] ofs);
      hit = (a == AW'(ofs));
   endfunction

   function automatic logic [11:0] ev_ofs(input int idx);
      case (idx)
         quadrature_decoder_pkg::EV_SAMPLE: ev_ofs = quadrature_decoder_pkg::OFS_EV_SAMPLE;
         quadrature_decoder_pkg::EV_REPORT: ev_ofs = quadrature_decoder_pkg::OFS_EV_REPORT;
         quadrature_decoder_pkg::EV_OVF:    ev_ofs = quadrature_decoder_pkg::OFS_EV_OVF;
         quadrature_decoder_pkg::EV_DOUBLE: ev_ofs = quadrature_decoder_pkg::OFS_EV_DOUBLE;
         default:             ev_ofs = quadrature_decoder_pkg::OFS_EV_HALT;
      endcase
   endfunction

   function automatic logic mapped(input logic [AW-1:0] a);
      mapped = hit(a, quadrature_decoder_pkg::OFS_TASK_STOP) || hit(a, quadrature_decoder_pkg::OFS_TASK_BOTH)
            || hit(a, quadrature_decoder_pkg::OFS_TASK_STEPS) || hit(a, quadrature_decoder_pkg::OFS_TASK_DBLS)
            || hit(a, quadrature_decoder_pkg::OFS_EV_SAMPLE) || hit(a, quadrature_decoder_pkg::OFS_EV_REPORT)
            || hit(a, quadrature_decoder_pkg::OFS_EV_OVF) || hit(a, quadrature_decoder_pkg::OFS_EV_DOUBLE)
            || hit(a, quadrature_decoder_pkg::OFS_EV_HALT) || hit(a, quadrature_decoder_pkg::OFS_LINKS)
            || hit(a, quadrature_decoder_pkg::OFS_IRQ_SET) || hit(a, quadrature_decoder_pkg::OFS_STEP_TOT)
            || hit(a, quadrature_decoder_pkg::OFS_STEP_SNAP) || hit(a, quadrature_decoder_pkg::OFS_DBL_TOT)
            || hit(a, quadrature_decoder_pkg::OFS_DBL_SNAP) || hit(a, quadrature_decoder_pkg::OFS_REPORT_CNT);
   endfunction

   axil_regs_port #(
      .AW (AW)
   ) u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // Every control field lives in byte lane 0
   assign wr_lane0 = wr_en && wr_strb[0];
   assign wr_ok    = mapped(wr_addr);
   assign rd_ok    = mapped(rd_addr);

   // Event sources
   assign new_sample_event         = sample_strobe;
   assign motion_report_event      = report_due_r && (step_total != '0);
   assign double_step_report_event = report_due_r && (double_step_total != '0);
   assign total_overflow_event     = step_ovf || dbl_ovf;

   always_comb begin
      ev_pulse                      = '0;
      ev_pulse[quadrature_decoder_pkg::EV_SAMPLE] = new_sample_event;
      ev_pulse[quadrature_decoder_pkg::EV_REPORT] = motion_report_event;
      ev_pulse[quadrature_decoder_pkg::EV_OVF]    = total_overflow_event;
      ev_pulse[quadrature_decoder_pkg::EV_DOUBLE] = double_step_report_event;
      ev_pulse[quadrature_decoder_pkg::EV_HALT]   = halt_done;
   end

   // Tasks from software writes or from enabled links
   assign snap_clear_both_task =
      (wr_lane0 && wr_data[0] && hit(wr_addr, quadrature_decoder_pkg::OFS_TASK_BOTH))
      || (links_r[quadrature_decoder_pkg::LNK_REPORT_BOTH] && motion_report_event)
      || (links_r[quadrature_decoder_pkg::LNK_SAMPLE_BOTH] && new_sample_event);

   assign snap_clear_steps_task =
      (wr_lane0 && wr_data[0] && hit(wr_addr, quadrature_decoder_pkg::OFS_TASK_STEPS))
      || (links_r[quadrature_decoder_pkg::LNK_REPORT_STEPS] && motion_report_event);

   assign snap_clear_doubles_task =
      (wr_lane0 && wr_data[0] && hit(wr_addr, quadrature_decoder_pkg::OFS_TASK_DBLS))
      || (links_r[quadrature_decoder_pkg::LNK_DOUBLE_DBLS] && double_step_report_event);

   assign stop_nxt =
      (wr_lane0 && wr_data[0] && hit(wr_addr, quadrature_decoder_pkg::OFS_TASK_STOP))
      || (links_r[quadrature_decoder_pkg::LNK_SAMPLE_STOP] && new_sample_event)
      || (links_r[quadrature_decoder_pkg::LNK_REPORT_STOP] && motion_report_event)
      || (links_r[quadrature_decoder_pkg::LNK_DOUBLE_STOP] && double_step_report_event);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_task <= 1'b0;
      end else begin
         stop_task <= stop_nxt;
      end
   end

   // Both totals snap together on the both task so the pair stays coherent
   event_total #(
      .W         (STEP_W),
      .IS_SIGNED (1'b1)
   ) u_steps (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .inc_valid (sample_strobe),
      .inc       (sample_value),
      .snap      (snap_clear_both_task || snap_clear_steps_task),
      .total     (step_total),
      .snapshot  (step_total_snapshot),
      .overflow  (step_ovf)
   );

   event_total #(
      .W         (DBL_W),
      .IS_SIGNED (1'b0)
   ) u_doubles (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .inc_valid (double_strobe),
      .inc       (2'h1),
      .snap      (snap_clear_both_task || snap_clear_doubles_task),
      .total     (double_step_total),
      .snapshot  (double_step_snapshot),
      .overflow  (dbl_ovf)
   );

   // A count of zero would never report, so it acts as one
   assign report_lim = (report_cnt_r == '0) ? quadrature_decoder_pkg::REPORT_CNT_W'(1) : report_cnt_r;

   // Report check runs one edge after the last sample, on the updated totals
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_cnt_r <= '0;
         report_due_r <= 1'b0;
         cnt_state_r  <= CNT_IDLE;
      end else begin
         report_due_r <= 1'b0;
         case (cnt_state_r)
            CNT_IDLE: begin
               if (sample_strobe) begin
                  if (report_lim == quadrature_decoder_pkg::REPORT_CNT_W'(1)) begin
                     report_due_r <= 1'b1;
                  end else begin
                     sample_cnt_r <= quadrature_decoder_pkg::REPORT_CNT_W'(1);
                     cnt_state_r  <= CNT_RUN;
                  end
               end
            end
            CNT_RUN: begin
               if (sample_strobe) begin
                  if (sample_cnt_r + quadrature_decoder_pkg::REPORT_CNT_W'(1) >= report_lim) begin
                     report_due_r <= 1'b1;
                     sample_cnt_r <= '0;
                     cnt_state_r  <= CNT_IDLE;
                  end else begin
                     sample_cnt_r <= sample_cnt_r + quadrature_decoder_pkg::REPORT_CNT_W'(1);
                  end
               end
            end
            default: begin
               sample_cnt_r <= '0;
               cnt_state_r  <= CNT_IDLE;
            end
         endcase
      end
   end

   // Event flags: hardware set beats a software clear in the same edge
   for (genvar i = 0; i < quadrature_decoder_pkg::EV_N; i++) begin : g_flag
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            ev_flag_r[i] <= quadrature_decoder_pkg::EV_FLAGS_RST[i];
         end else if (ev_pulse[i]) begin
            ev_flag_r[i] <= 1'b1;
         end else if (wr_lane0 && hit(wr_addr, ev_ofs(i))) begin
            ev_flag_r[i] <= wr_data[0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         links_r <= quadrature_decoder_pkg::LINKS_RST;
      end else if (wr_lane0 && hit(wr_addr, quadrature_decoder_pkg::OFS_LINKS)) begin
         links_r <= wr_data[quadrature_decoder_pkg::LINKS_W-1:0];
      end
   end

   // Only ones take effect; no clear path exists in this bank
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_r <= quadrature_decoder_pkg::IRQ_EN_RST;
      end else if (wr_lane0 && hit(wr_addr, quadrature_decoder_pkg::OFS_IRQ_SET)) begin
         irq_en_r <= irq_en_r | wr_data[quadrature_decoder_pkg::EV_N-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         report_cnt_r <= quadrature_decoder_pkg::REPORT_CNT_RST;
      end else if (wr_lane0 && hit(wr_addr, quadrature_decoder_pkg::OFS_REPORT_CNT)) begin
         report_cnt_r <= wr_data[quadrature_decoder_pkg::REPORT_CNT_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_flag_r & irq_en_r);
      end
   end

   // Read decode; task registers read as zero
   always_comb begin
      rd_data = '0;
      if (hit(rd_addr, quadrature_decoder_pkg::OFS_EV_SAMPLE)) begin
         rd_data[0] = ev_flag_r[quadrature_decoder_pkg::EV_SAMPLE];
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_EV_REPORT)) begin
         rd_data[0] = ev_flag_r[quadrature_decoder_pkg::EV_REPORT];
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_EV_OVF)) begin
         rd_data[0] = ev_flag_r[quadrature_decoder_pkg::EV_OVF];
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_EV_DOUBLE)) begin
         rd_data[0] = ev_flag_r[quadrature_decoder_pkg::EV_DOUBLE];
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_EV_HALT)) begin
         rd_data[0] = ev_flag_r[quadrature_decoder_pkg::EV_HALT];
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_LINKS)) begin
         rd_data[quadrature_decoder_pkg::LINKS_W-1:0] = links_r;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_IRQ_SET)) begin
         rd_data[quadrature_decoder_pkg::EV_N-1:0] = irq_en_r;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_STEP_TOT)) begin
         rd_data[STEP_W-1:0] = step_total;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_STEP_SNAP)) begin
         rd_data[STEP_W-1:0] = step_total_snapshot;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_DBL_TOT)) begin
         rd_data[DBL_W-1:0] = double_step_total;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_DBL_SNAP)) begin
         rd_data[DBL_W-1:0] = double_step_snapshot;
      end else if (hit(rd_addr, quadrature_decoder_pkg::OFS_REPORT_CNT)) begin
         rd_data[quadrature_decoder_pkg::REPORT_CNT_W-1:0] = report_cnt_r;
      end
   end
endmodule

// *** dv/quadrature_decoder_chk.sv ***
// Port-level checks of the shortcut and interrupt bank
`timescale 1ns/1ps
module bank_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // Core side
   input wire logic sample_strobe,
   input wire logic stop_task,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   chk_read_single: assert property (rvalid && rready |=> !rvalid)
      else $error("read data repeated");
   chk_resp_single: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   chk_ar_blocked: assert property (rvalid |-> !arready)
      else $error("read address taken while data pending");
   chk_wr_blocked: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   chk_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   // Stop only from a sample, a report one cycle on, or a task write
   chk_stop_cause: assert property (stop_task |->
      $past(sample_strobe) || $past(sample_strobe, 2) || bvalid)
      else $error("stop without cause");
   chk_quiet_reset: assert property ($rose(aresetn) |-> !irq && !stop_task)
      else $error("outputs active after reset");
endmodule
bind quad_decoder_shortcut_irq bank_chk u_chk (.*);

// *** dv/tb.sv ***
// Self-checking bench for the shortcut and interrupt bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
   logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, arvalid = '0;
   logic        bready = '1, rready = '1, sample_strobe = '0, double_strobe = '0;
   logic        halt_done = '0, awready, wready, bvalid, arready, rvalid, stop_task, irq;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd_d, seed = 32'h05D64F16;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  sample_value = '0, bresp, rresp, rd_r, wr_resp;
   logic [4:0]  en = '0;
   int          bad_count = 0, checks = 0, stops = 0, cyc = 0, n;
   quad_decoder_shortcut_irq dut (.*);
   always #20 aclk = ~aclk;
   // Counted mid-cycle so the pulse is settled
   always @(negedge aclk) if (stop_task === 1'h1) stops++;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Totals after two +1 pulses when link i is the only one set
   function automatic logic [31:0] exp_tot(input int i, input int k);
      return (i == 6) ? 32'h1 : (i == 0 || i == k) ? 32'h0 : 32'h2;
   endfunction
   task report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Handshakes read mid-cycle, what the next rising edge will see
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w, b;
      awaddr <= a;
      wdata <= d;
      awvalid <= '1;
      wvalid <= '1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         wr_resp = bresp;
         @(posedge aclk);
         if (aw) awvalid <= '0;
         if (w) wvalid <= '0;
         if (b) break;
      end
      // A wait that runs out is a mismatch
      if (n == 40) bad_count++;
   endtask
   task rd(input logic [11:0] a);
      logic ar, r;
      araddr <= a;
      arvalid <= '1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ar = arvalid & arready;
         r = rvalid;
         rd_d = rdata;
         rd_r = rresp;
         @(posedge aclk);
         if (ar) arvalid <= '0;
         if (r) break;
      end
      if (n == 40) bad_count++;
   endtask
   task chk_rd(input logic [11:0] a, input logic [31:0] e, input string s);
      rd(a);
      `CHK(s, e, rd_d)
   endtask
   task pulse(input logic s, input logic [1:0] v, input logic d, input logic h);
      sample_strobe <= s;
      sample_value <= v;
      double_strobe <= d;
      halt_done <= h;
      @(posedge aclk);
      sample_strobe <= '0;
      double_strobe <= '0;
      halt_done <= '0;
      repeat (4) @(posedge aclk);
   endtask
   task irq_is(input logic e);
      @(negedge aclk);
      `CHK("irq", e, irq)
      @(posedge aclk);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= '1;
      @(posedge aclk);
      chk_rd(12'h200, 32'h0, "links reset");
      chk_rd(12'h304, 32'h0, "enable reset");
      chk_rd(12'h110, 32'h0, "halt reset");
      rd(12'hFFC);
      `CHK("unmapped resp", 2'h2, rd_r)
      wr(12'hFFC, 32'h0);
      `CHK("unmapped bresp", 2'h2, wr_resp)
      repeat (5) begin
         seed = lfsr(seed);
         en = en | seed[4:0];
         wr(12'h304, seed);
         `CHK("bresp", 2'h0, wr_resp)
         chk_rd(12'h304, {27'h0, en}, "enable set");
         wr(12'h200, seed);
         chk_rd(12'h200, {25'h0, seed[6:0]}, "links");
      end
      wr(12'h304, 32'h0);
      chk_rd(12'h304, {27'h0, en}, "enable zero write");
      wr(12'h600, 32'h1);
      for (int i = 0; i < 7; i++) begin
         wr(12'h200, 32'h0);
         wr(12'h008, 32'h1);
         pulse('1, 2'h1, '1, '0);
         wr(12'h200, 32'h1 << i);
         stops = 0;
         pulse('1, 2'h1, '1, '0);
         wr(12'h200, 32'h0);
         `CHK("stop count", (i % 2 == 1) ? 1 : 0, stops)
         chk_rd(12'h514, exp_tot(i, 2), "step total");
         chk_rd(12'h544, exp_tot(i, 4), "double total");
         // Snap on the sample edge sees one step, a report snap sees two
         if (exp_tot(i, 2) != 32'h2)
            chk_rd(12'h518, (i == 6) ? 32'h1 : 32'h2, "step snap");
         if (exp_tot(i, 4) != 32'h2)
            chk_rd(12'h548, (i == 6) ? 32'h1 : 32'h2, "double snap");
      end
      wr(12'h008, 32'h1);
      wr(12'h200, 32'h8);
      for (int a = 12'h100; a <= 12'h110; a += 4) wr(a[11:0], 32'h0);
      stops = 0;
      pulse('1, 2'h0, '1, '0);
      `CHK("stop on zero total", 0, stops)
      chk_rd(12'h104, 32'h0, "report flag");
      chk_rd(12'h10C, 32'h1, "double flag");
      chk_rd(12'h100, 32'h1, "sample flag");
      wr(12'h304, 32'h1F);
      for (int a = 12'h100; a <= 12'h110; a += 4) wr(a[11:0], 32'h0);
      irq_is('0);
      pulse('0, 2'h0, '0, '1);
      irq_is('1);
      chk_rd(12'h110, 32'h1, "halt flag");
      // Report count above one runs the sample counter
      wr(12'h600, 32'h3);
      wr(12'h008, 32'h1);
      wr(12'h104, 32'h0);
      repeat (2) pulse('1, 2'h1, '0, '0);
      chk_rd(12'h104, 32'h0, "report early");
      pulse('1, 2'h1, '0, '0);
      chk_rd(12'h104, 32'h1, "report on count");
      wr(12'h00C, 32'h1);
      chk_rd(12'h518, 32'h3, "steps task snap");
      chk_rd(12'h514, 32'h0, "steps task clear");
      // Double total saturates at its limit and flags overflow
      repeat (16) pulse('0, 2'h0, '1, '0);
      chk_rd(12'h544, 32'hF, "double saturate");
      chk_rd(12'h108, 32'h1, "overflow flag");
      wr(12'h010, 32'h1);
      chk_rd(12'h548, 32'hF, "doubles task snap");
      chk_rd(12'h544, 32'h0, "doubles task clear");
      stops = 0;
      wr(12'h004, 32'h1);
      `CHK("stop task write", 1, stops)
      report_and_stop();
   end
endmodule
